// >>> core/nfr_flash_if.sv
// Purpose: Flash bank interface with scrambler and read-data bit tally
// Assumes: Synchronous active-low reset, one clock, Avalon-MM slave
// Notes:   One access at a time; every access ends in one ACK cycle
// Function
// - Hold bit 1 keeps a flash-selected bank's select asserted; 0 gives ordinary access timing.
// - One flash-select bit per bank 1-6 repartitions that bank's space.
// - With flash boot strap, bank 1's flash-select resets to 1, else to 0; banks 2-6 reset to 0.
// - Select bits at even positions, hold bits at odd positions.
// - Writing 1 to bit 5 clears the tally; bit is write-only.
// - Bit 4 chooses counting zeros (0) or ones (1) in read data.
// - Tally advances only while enable bit 3 is 1.
// - 32-bit tally accumulates across reads until cleared; resets to zero.
// - Writing 1 to bit 1 reloads the seed to its initial value.
// - Bit 0 enables scrambling of write and read data; resets to 0.
// - Readable writable 23-bit seed, low 15 bits reset to 0x5aa5.
// - On flash boot, boot code copies the first 8K bytes inward.
// - On flash boot, page size straps are readable by software.
// - Writes to the address partition become address-latch cycles.
// - Data partition reads/writes become data cycles; DMA may use them.
// - Cycle timing comes from the bank's timing setting; select by hold.
// - Pins: bank select, read and write strobes, two low address lines.
// - Eight- or sixteen-bit flash parts on any bank 1-6.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module nfr_flash_if
  import nfr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // Straps
  input wire logic bootFromFlash,
  input wire logic [2:0] bootPageSel,
  // Flash pins
  output nfr_pins_t flashPins,
  output nfr_data_t flashDataOut,
  input wire logic [15:0] flashDataIn,
  input wire logic flashReadyBusyN
);
  nfr_state_t stateQ, stateD;
  logic [3:0] cntQ, cntD;
  logic [2:0] bankQ, bankD;
  logic writeQ, writeD, cleQ, cleD, aleQ, aleD;
  logic [15:0] wdataQ, wdataD;
  logic [31:0] rdataQ, rdataD;
  logic [NBANK-1:0] flashEnQ, flashEnD, holdQ, holdD;
  logic [TM_W-1:0] timingQ [NBANK];
  logic [TM_W-1:0] timingD [NBANK];
  logic scrEnQ, scrEnD, tallyEnQ, tallyEnD, tallyPolQ, tallyPolD;
  logic [SEED_W-1:0] seedQ, seedD;
  logic [31:0] tallyQ, tallyD;
  logic [2:0] bootPageQ;
  logic req, regSel, bankOk, flashAcc, busy, dataPart, wide;
  logic [14:0] ofs;
  logic [2:0] bankNum, bIdx;
  logic [TM_W-1:0] tm;
  logic [15:0] rawIn, scrMask, wrMask, rdWord;
  logic [4:0] onesCnt;
  logic [31:0] regWord, oldWord;

  function automatic logic [4:0] count_ones(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [SEED_W-1:0] seed_step(input logic [SEED_W-1:0] s);
    return {s[SEED_W-2:0], s[SEED_W-1] ^ s[SEED_TAP]};
  endfunction

  // Address decode of the held request
  always_comb begin
    req = avsRead | avsWrite;
    regSel = ~avsAddress[WIN_BIT];
    ofs = avsAddress[14:0];
    bankNum = avsAddress[BANK_MSB:BANK_LSB];
    bankOk = (bankNum >= BANK_FIRST) && (bankNum <= BANK_LAST);
    bIdx = bankNum - BANK_FIRST;
    flashAcc = ~regSel && bankOk && flashEnQ[bIdx];
  end

  // Register read value, sampled into rdataQ on entry to ACK
  always_comb begin
    regWord = 32'h0000_0000;
    if (ofs == OFS_BANKCTL) begin
      for (int i = 0; i < NBANK; i++) begin
        regWord[2*i] = flashEnQ[i];
        regWord[2*i+1] = holdQ[i];
      end
    end else if (ofs == OFS_SCRCTL) begin
      regWord[CTL_SCR_EN] = scrEnQ;
      regWord[CTL_TALLY_EN] = tallyEnQ;
      regWord[CTL_TALLY_POL] = tallyPolQ;
    end else if (ofs == OFS_SEED) begin
      regWord[SEED_W-1:0] = seedQ;
    end else if (ofs == OFS_TALLY) begin
      regWord = tallyQ;
    end else if (ofs == OFS_BOOTSTAT) begin
      // Page size straps and live ready/busy level
      regWord[2:0] = bootPageQ;
      regWord[3] = flashReadyBusyN;
    end else if (ofs[14:5] == 10'h000 && ofs[1:0] == 2'h0 &&
        ofs[4:2] < 3'(NBANK)) begin
      regWord[TM_W-1:0] = timingQ[ofs[4:2]];
    end
  end

  // Current bank timing and data path
  always_comb begin
    tm = timingQ[bankQ];
    wide = tm[TM_WIDE];
    dataPart = ~cleQ & ~aleQ;
    busy = (stateQ == ST_SETUP) || (stateQ == ST_STROBE) ||
           (stateQ == ST_HOLD);
    wrMask = wide ? 16'hffff : 16'h00ff;
    rawIn = flashDataIn & wrMask;
    scrMask = (scrEnQ && dataPart) ? (seedQ[15:0] & wrMask) : 16'h0000;
    rdWord = rawIn ^ scrMask;
    onesCnt = count_ones(rdWord);
  end

  // Sequencer and register file next values
  always_comb begin
    stateD = stateQ;
    cntD = cntQ;
    bankD = bankQ;
    writeD = writeQ;
    cleD = cleQ;
    aleD = aleQ;
    wdataD = wdataQ;
    rdataD = rdataQ;
    flashEnD = flashEnQ;
    holdD = holdQ;
    timingD = timingQ;
    scrEnD = scrEnQ;
    tallyEnD = tallyEnQ;
    tallyPolD = tallyPolQ;
    seedD = seedQ;
    tallyD = tallyQ;
    oldWord = 32'h0000_0000;
    case (stateQ)
      ST_IDLE: begin
        if (req) begin
          if (flashAcc) begin
            bankD = bIdx;
            writeD = avsWrite;
            cleD = avsAddress[CLE_BIT];
            aleD = avsAddress[ALE_BIT];
            wdataD = avsWriteData[15:0] & (timingQ[bIdx][TM_WIDE] ?
                     16'hffff : 16'h00ff);
            if (scrEnQ && !avsAddress[CLE_BIT] && !avsAddress[ALE_BIT]) begin
              wdataD = wdataD ^ seedQ[15:0];
            end
            // Counts come from the bank's own timing setting
            cntD = timingQ[bIdx][TM_SETUP_LSB +: 4];
            stateD = ST_SETUP;
          end else begin
            // Registers, unmapped addresses and non-flash banks
            rdataD = regSel ? regWord : 32'h0000_0000;
            stateD = ST_ACK;
          end
        end
      end
      ST_SETUP: begin
        if (cntQ == 4'h0) begin
          cntD = tm[TM_STROBE_LSB +: 4];
          stateD = ST_STROBE;
        end else begin
          cntD = cntQ - 4'h1;
        end
      end
      ST_STROBE: begin
        if (cntQ == 4'h0) begin
          if (!writeQ) begin
            rdataD = {16'h0000, rdWord};
            if (dataPart && tallyEnQ) begin
              tallyD = tallyQ + {27'h0, tallyPolQ ? onesCnt :
                       ((wide ? WIDTH16 : WIDTH8) - onesCnt)};
            end
          end
          if (dataPart && scrEnQ) begin
            seedD = seed_step(seedQ);
          end
          cntD = tm[TM_HOLD_LSB +: 4];
          stateD = ST_HOLD;
        end else begin
          cntD = cntQ - 4'h1;
        end
      end
      ST_HOLD: begin
        if (cntQ == 4'h0) begin
          stateD = ST_ACK;
        end else begin
          cntD = cntQ - 4'h1;
        end
      end
      ST_ACK: begin
        // Register writes take effect on the edge that ends the wait
        if (avsWrite && regSel) begin
          oldWord = merge_be(regWord, avsWriteData, avsByteEnable);
          if (ofs == OFS_BANKCTL) begin
            for (int i = 0; i < NBANK; i++) begin
              flashEnD[i] = oldWord[2*i];
              holdD[i] = oldWord[2*i+1];
            end
          end else if (ofs == OFS_SCRCTL) begin
            scrEnD = oldWord[CTL_SCR_EN];
            tallyEnD = oldWord[CTL_TALLY_EN];
            tallyPolD = oldWord[CTL_TALLY_POL];
            if (oldWord[CTL_TALLY_CLR]) begin
              tallyD = 32'h0000_0000;
            end
            if (oldWord[CTL_SEED_RELOAD]) begin
              seedD = SEED_RESET;
            end
          end else if (ofs == OFS_SEED) begin
            seedD = oldWord[SEED_W-1:0];
          end else if (ofs == OFS_TALLY) begin
            tallyD = oldWord;
          end else if (ofs[14:5] == 10'h000 && ofs[1:0] == 2'h0 &&
              ofs[4:2] < 3'(NBANK)) begin
            timingD[ofs[4:2]] = oldWord[TM_W-1:0];
          end
        end
        stateD = ST_IDLE;
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stateQ <= ST_IDLE;
      cntQ <= 4'h0;
      bankQ <= 3'h0;
      writeQ <= 1'b0;
      cleQ <= 1'b0;
      aleQ <= 1'b0;
      wdataQ <= 16'h0000;
      rdataQ <= 32'h0000_0000;
      // Synchronous reset, so the strap may be loaded here directly
      flashEnQ <= {{(NBANK-1){1'b0}}, bootFromFlash};
      holdQ <= '0;
      for (int i = 0; i < NBANK; i++) begin
        timingQ[i] <= TM_RESET;
      end
      scrEnQ <= 1'b0;
      tallyEnQ <= 1'b0;
      tallyPolQ <= 1'b0;
      seedQ <= SEED_RESET;
      tallyQ <= 32'h0000_0000;
      // Boot code sizes its copy of BOOT_COPY_BYTES from these straps
      bootPageQ <= bootPageSel;
    end else begin
      stateQ <= stateD;
      cntQ <= cntD;
      bankQ <= bankD;
      writeQ <= writeD;
      cleQ <= cleD;
      aleQ <= aleD;
      wdataQ <= wdataD;
      rdataQ <= rdataD;
      flashEnQ <= flashEnD;
      holdQ <= holdD;
      timingQ <= timingD;
      scrEnQ <= scrEnD;
      tallyEnQ <= tallyEnD;
      tallyPolQ <= tallyPolD;
      seedQ <= seedD;
      tallyQ <= tallyD;
    end
  end

  // Pins follow the state directly so strobes line up with data capture
  always_comb begin
    for (int i = 0; i < NBANK; i++) begin
      flashPins.bankSelectN[i] = ~((flashEnQ[i] & holdQ[i]) |
                                   (busy && bankQ == 3'(i)));
    end
    flashPins.flashReadStrobeN = ~(stateQ == ST_STROBE && !writeQ);
    flashPins.flashWriteStrobeN = ~(stateQ == ST_STROBE && writeQ);
    flashPins.cmdLatch = busy & cleQ;
    flashPins.addrLatch = busy & aleQ;
    flashDataOut.value = wdataQ;
    flashDataOut.oe = busy & writeQ;
    avsWaitRequest = req && (stateQ != ST_ACK);
    avsReadData = rdataQ;
  end

  // Checks
  logic scrWrAck;
  assign scrWrAck = (stateQ == ST_ACK) && avsWrite && regSel &&
                    (ofs == OFS_SCRCTL) && avsByteEnable[0];

  a_hold_keeps_cs: assert property (@(posedge mclk) disable iff (!rst_n)
    ((flashEnQ & holdQ & flashPins.bankSelectN) == '0))
    else $error("held bank select released");
  a_idle_cs_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (stateQ == ST_IDLE) |-> (flashPins.bankSelectN == ~(flashEnQ & holdQ)))
    else $error("bank select wrong while idle");
  a_boot_strap: assert property (@(posedge mclk)
    (!rst_n ##1 rst_n) |-> (flashEnQ == {5'h00, $past(bootFromFlash)}))
    else $error("flash select reset value wrong");
  a_tally_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (scrWrAck && avsWriteData[CTL_TALLY_CLR]) |=> (tallyQ == 32'h0))
    else $error("tally not cleared");
  a_tally_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    (!tallyEnQ && stateQ != ST_ACK) |=> $stable(tallyQ))
    else $error("tally moved while disabled");
  a_tally_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
    (stateQ == ST_STROBE && cntQ == 4'h0 && !writeQ && dataPart &&
     tallyEnQ && !tallyPolQ && rdWord == wrMask)
    |=> $stable(tallyQ))
    else $error("zero count tallied ones");
  a_seed_reload: assert property (@(posedge mclk) disable iff (!rst_n)
    (scrWrAck && avsWriteData[CTL_SEED_RELOAD]) |=> (seedQ == SEED_RESET))
    else $error("seed not reloaded");
  a_plain_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (busy && writeQ && !scrEnQ && stateQ == ST_STROBE)
    |-> (flashDataOut.value == (avsWriteData[15:0] & wrMask)))
    else $error("unscrambled data altered");
  a_cmd_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
    (stateQ == ST_IDLE && avsWrite && flashAcc && avsAddress[CLE_BIT] &&
     !avsAddress[ALE_BIT]) |=> (flashPins.cmdLatch && !flashPins.addrLatch))
    else $error("command latch missing");
  a_addr_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
    (stateQ == ST_IDLE && avsWrite && flashAcc && avsAddress[ALE_BIT] &&
     !avsAddress[CLE_BIT]) |=> (flashPins.addrLatch && !flashPins.cmdLatch))
    else $error("address latch missing");
  a_read_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
    (stateQ == ST_IDLE && avsRead && flashAcc)
    |-> ##[1:17] !flashPins.flashReadStrobeN)
    else $error("read strobe never issued");
  a_setup_len: assert property (@(posedge mclk) disable iff (!rst_n)
    (stateQ == ST_SETUP && cntQ == 4'h0) |=> (stateQ == ST_STROBE))
    else $error("setup count overrun");

  c_cmd_write: cover property (@(posedge mclk) disable iff (!rst_n)
    flashPins.cmdLatch && !flashPins.flashWriteStrobeN);
  c_data_read: cover property (@(posedge mclk) disable iff (!rst_n)
    !flashPins.flashReadStrobeN && dataPart && scrEnQ);
  c_seed_reload: cover property (@(posedge mclk) disable iff (!rst_n)
    scrWrAck && avsWriteData[CTL_SEED_RELOAD]);
  c_hold_select: cover property (@(posedge mclk) disable iff (!rst_n)
    (flashEnQ & holdQ) != '0 && stateQ == ST_IDLE);
endmodule

// >>> core/nfr_pkg.sv
// Purpose: Shared constants and types of the flash bank interface block
// Assumes: Avalon-MM byte addressing, 32-bit data, 16-bit flash data pins
// Notes:   Offsets are byte offsets inside the block's register region
package nfr_pkg;
  localparam int ADDR_W = 16;
  localparam int NBANK = 6;
  localparam int SEED_W = 23;
  localparam int TM_W = 13;
  // Register region offsets
  localparam logic [14:0] OFS_TIMING0 = 15'h0000;
  localparam logic [14:0] OFS_BOOTSTAT = 15'h0020;
  localparam logic [14:0] OFS_BANKCTL = 15'h0050;
  localparam logic [14:0] OFS_SCRCTL = 15'h0100;
  localparam logic [14:0] OFS_SEED = 15'h0104;
  localparam logic [14:0] OFS_TALLY = 15'h0108;
  // Scrambler and tally control fields
  localparam int CTL_SCR_EN = 0;
  localparam int CTL_SEED_RELOAD = 1;
  localparam int CTL_TALLY_EN = 3;
  localparam int CTL_TALLY_POL = 4;
  localparam int CTL_TALLY_CLR = 5;
  localparam logic [SEED_W-1:0] SEED_RESET = 23'h005aa5;
  localparam int SEED_TAP = 17;
  // Per-bank timing fields: setup, strobe, hold counts, wide bus
  localparam int TM_SETUP_LSB = 0;
  localparam int TM_STROBE_LSB = 4;
  localparam int TM_HOLD_LSB = 8;
  localparam int TM_WIDE = 12;
  localparam logic [TM_W-1:0] TM_RESET = 13'h0777;
  // Flash window layout: bank number and the two latch-select lines
  localparam int WIN_BIT = 15;
  localparam int BANK_MSB = 14;
  localparam int BANK_LSB = 12;
  localparam int ALE_BIT = 1;
  localparam int CLE_BIT = 0;
  localparam logic [2:0] BANK_FIRST = 3'h1;
  localparam logic [2:0] BANK_LAST = 3'h6;
  localparam logic [4:0] WIDTH16 = 5'h10;
  localparam logic [4:0] WIDTH8 = 5'h08;
  // Boot loader copies this many bytes from flash into internal memory
  localparam int BOOT_COPY_BYTES = 8192;

  typedef struct packed {
    logic [NBANK-1:0] bankSelectN;
    logic flashReadStrobeN;
    logic flashWriteStrobeN;
    logic cmdLatch;
    logic addrLatch;
  } nfr_pins_t;

  typedef struct packed {
    logic [15:0] value;
    logic oe;
  } nfr_data_t;

  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_ACK} nfr_state_t;
endpackage

// >>> testbench/nfr_flash_model.sv
// Purpose: Behavioural flash part on the far side of the bank interface
// Assumes: Pins sampled on the system clock; one part on any selected bank
// Notes:   Released data lines show a toggling pattern, not the last value
`timescale 1ns/1ps
module nfr_flash_model
  import nfr_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Pins from the interface
  input wire nfr_pins_t flashPins,
  input wire nfr_data_t flashDataOut,
  input wire logic [15:0] readValue,
  // Pins back to the interface
  output logic [15:0] flashDataIn,
  output logic flashReadyBusyN,
  // Observation
  output logic [1:0] lastKind,
  output logic [15:0] lastWord,
  output int nStrobes
);
  logic prevWe;
  logic prevRe;
  logic [15:0] lastOut;
  int busyCnt;
  logic selected;

  initial begin
    prevWe = 1'b1;
    prevRe = 1'b1;
    lastOut = 16'h0000;
    busyCnt = 0;
    lastKind = 2'b00;
    lastWord = 16'h0000;
    nStrobes = 0;
  end

  assign selected = ~&flashPins.bankSelectN;
  // No pull on the data lines, so an undriven bus must not look stable
  assign flashDataIn = !flashPins.flashReadStrobeN ? readValue : ~lastOut;
  assign flashReadyBusyN = (busyCnt == 0);

  always @(posedge mclk) begin
    prevWe <= flashPins.flashWriteStrobeN;
    prevRe <= flashPins.flashReadStrobeN;
    lastOut <= flashDataIn;
    if (busyCnt > 0) begin
      busyCnt <= busyCnt - 1;
    end
    if (flashPins.flashWriteStrobeN && !prevWe && selected) begin
      lastKind <= {flashPins.cmdLatch, flashPins.addrLatch};
      // Undriven data lines latch garbage, shown as the inverted word
      lastWord <= flashDataOut.oe ? flashDataOut.value :
                  ~flashDataOut.value;
      nStrobes <= nStrobes + 1;
      // A command keeps the part busy for a while
      if (flashPins.cmdLatch) begin
        busyCnt <= 32;
      end
    end
    if (flashPins.flashReadStrobeN && !prevRe) begin
      nStrobes <= nStrobes + 1;
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench of the flash bank interface
// Assumes: Avalon-MM master tasks; behavioural flash part on the pins
// Notes:   Wait counts are the cycles the bench saw waitrequest high
`timescale 1ns/1ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin nFail++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_top
  import nfr_pkg::*;
;
  localparam logic [15:0] WCMD1 = 16'h9001;
  localparam logic [15:0] WADR1 = 16'h9002;
  localparam logic [15:0] WDAT1 = 16'h9000;
  localparam logic [15:0] WDAT2 = 16'ha000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] avsAddress = 16'h0000;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0000_0000;
  logic [3:0] avsByteEnable = 4'hf;
  logic bootFromFlash = 1'b0;
  logic [2:0] bootPageSel = 3'h5;
  logic [15:0] readValue = 16'h00f3;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  nfr_pins_t flashPins;
  nfr_data_t flashDataOut;
  logic [15:0] flashDataIn;
  logic flashReadyBusyN;
  logic [1:0] lastKind;
  logic [15:0] lastWord;
  int nStrobes;
  int nFail = 0;
  int testsRun = 0;

  always #2.5 mclk = ~mclk;

  nfr_flash_if DUT (.mclk(mclk), .rst_n(rst_n), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .bootFromFlash(bootFromFlash),
    .bootPageSel(bootPageSel), .flashPins(flashPins),
    .flashDataOut(flashDataOut), .flashDataIn(flashDataIn),
    .flashReadyBusyN(flashReadyBusyN));

  nfr_flash_model flashModel (.mclk(mclk), .flashPins(flashPins),
    .flashDataOut(flashDataOut), .readValue(readValue),
    .flashDataIn(flashDataIn), .flashReadyBusyN(flashReadyBusyN),
    .lastKind(lastKind), .lastWord(lastWord), .nStrobes(nStrobes));

  function automatic logic [15:0] regA(input logic [14:0] o);
    return {1'b0, o};
  endfunction

  function automatic logic [SEED_W-1:0] nxt(input logic [SEED_W-1:0] s);
    return {s[21:0], s[22] ^ s[17]};
  endfunction

  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Entered just after a rising edge; leaves one edge after release
  task automatic bus(input logic wr, input logic [15:0] a,
      input logic [31:0] d, output logic [31:0] q, output int w);
    w = 0;
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWriteData <= d;
    @(posedge mclk);
    while (avsWaitRequest !== 1'b0) begin
      w++;
      @(posedge mclk);
    end
    q = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input int ew);
    logic [31:0] q;
    int w;
    bus(1'b1, a, d, q, w);
    `CHK("waits", ew, w)
  endtask

  task automatic chkRd(input string nm, input logic [15:0] a,
      input logic [31:0] e);
    logic [31:0] q;
    int w;
    bus(1'b0, a, 32'h0, q, w);
    `CHK(nm, e, q)
  endtask

  task automatic doReset(input logic boot);
    rst_n <= 1'b0;
    bootFromFlash <= boot;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic scReset();
    logic [31:0] q;
    int w;
    chkRd("bank ctl", regA(OFS_BANKCTL), 32'h0);
    chkRd("scr ctl", regA(OFS_SCRCTL), 32'h0);
    chkRd("seed", regA(OFS_SEED), 32'h005aa5);
    chkRd("tally", regA(OFS_TALLY), 32'h0);
    wr(16'h0200, 32'hffff_ffff, 1);
    chkRd("unmapped", 16'h0200, 32'h0);
    bus(1'b0, regA(OFS_BOOTSTAT), 32'h0, q, w);
    `CHK("straps", 4'hd, q[3:0])
  endtask

  task automatic scLatch();
    logic [31:0] q;
    int w;
    wr(regA(OFS_BANKCTL), 32'h1, 1);
    `CHK("idle sel", 6'h3f, flashPins.bankSelectN)
    wr(WCMD1, 32'h70, 25);
    `CHK("cmd kind", 2'b10, lastKind)
    `CHK("cmd word", 8'h70, lastWord[7:0])
    bus(1'b0, regA(OFS_BOOTSTAT), 32'h0, q, w);
    `CHK("busy", 1'b0, q[3])
    wr(regA(OFS_TIMING0), 32'h1312, 1);
    wr(WADR1, 32'h12, 10);
    `CHK("adr kind", 2'b01, lastKind)
    `CHK("adr word", 16'h0012, lastWord)
    wr(WDAT1, 32'hbeef, 10);
    `CHK("dat kind", 2'b00, lastKind)
    `CHK("dat word", 16'hbeef, lastWord)
  endtask

  task automatic scHold();
    wr(regA(OFS_BANKCTL), 32'h3, 1);
    `CHK("hold sel", 1'b0, flashPins.bankSelectN[0])
    chkRd("bank ctl", regA(OFS_BANKCTL), 32'h3);
    wr(regA(OFS_BANKCTL), 32'hc01, 1);
    `CHK("hold sel6", 6'h1f, flashPins.bankSelectN)
    wr(regA(OFS_BANKCTL), 32'h1, 1);
    `CHK("released", 6'h3f, flashPins.bankSelectN)
  endtask

  task automatic scRefuse();
    logic [31:0] q;
    int w;
    int n0;
    n0 = nStrobes;
    bus(1'b0, WDAT2, 32'h0, q, w);
    `CHK("off waits", 1, w)
    `CHK("off data", 32'h0, q)
    `CHK("off pins", n0, nStrobes)
  endtask

  task automatic scTally();
    logic [31:0] q;
    int w;
    wr(regA(OFS_SCRCTL), 32'h18, 1);
    repeat (2) begin
      bus(1'b0, WDAT1, 32'h0, q, w);
      `CHK("rd data", 16'h00f3, q[15:0])
    end
    chkRd("tally", regA(OFS_TALLY), 32'd12);
    wr(regA(OFS_SCRCTL), 32'h10, 1);
    bus(1'b0, WDAT1, 32'h0, q, w);
    chkRd("tally", regA(OFS_TALLY), 32'd12);
    wr(regA(OFS_SCRCTL), 32'h28, 1);
    chkRd("scr ctl", regA(OFS_SCRCTL), 32'h8);
    chkRd("tally", regA(OFS_TALLY), 32'd0);
    bus(1'b0, WDAT1, 32'h0, q, w);
    chkRd("tally", regA(OFS_TALLY), 32'd10);
    // A word of all ones holds no zeros, so the tally must not move
    readValue <= 16'hffff;
    bus(1'b0, WDAT1, 32'h0, q, w);
    `CHK("all ones", 16'hffff, q[15:0])
    chkRd("tally", regA(OFS_TALLY), 32'd10);
    readValue <= 16'h00f3;
    wr(regA(OFS_SCRCTL), 32'h0, 1);
  endtask

  task automatic scScramble();
    logic [31:0] q;
    int w;
    logic [SEED_W-1:0] s;
    wr(regA(OFS_SEED), 32'h123456, 1);
    chkRd("seed", regA(OFS_SEED), 32'h123456);
    wr(regA(OFS_SCRCTL), 32'h3, 1);
    chkRd("scr ctl", regA(OFS_SCRCTL), 32'h1);
    s = SEED_RESET;
    wr(WDAT1, 32'h0, 10);
    `CHK("scr wr1", s[15:0], lastWord)
    s = nxt(s);
    wr(WDAT1, 32'h0, 10);
    `CHK("scr wr2", s[15:0], lastWord)
    s = nxt(s);
    bus(1'b0, WDAT1, 32'h0, q, w);
    `CHK("scr rd", 16'h00f3 ^ s[15:0], q[15:0])
    wr(regA(OFS_SCRCTL), 32'h0, 1);
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    nFail++;
    stopTest();
  end

  initial begin
    doReset(1'b0);
    scReset();
    scLatch();
    scHold();
    scRefuse();
    scTally();
    scScramble();
    doReset(1'b1);
    chkRd("boot sel", regA(OFS_BANKCTL), 32'h1);
    stopTest();
  end
endmodule
